// *** src/prupk_top.sv ***
// Pixel rectangle unpacker: register slave, row walker, element fetch and RGBA expansion
`timescale 1ns/10ps
module prupk_top (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Avalon-MM register slave
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Client memory element fetch
   output prupk_pkg::prupk_mreq_s o_mem_req,
   output logic o_mem_req_valid,
   input wire logic i_mem_req_ready,
   input wire logic [15:0] i_mem_rdata,
   input wire logic i_mem_rvalid,
   // Expanded group stream to image storage
   output prupk_pkg::prupk_rgba_s o_pix,
   output logic o_pix_valid,
   input wire logic i_pix_ready,
   output logic o_pix_last
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_REQ = 5'b00010,
      ST_WAIT = 5'b00100,
      ST_EMIT = 5'b01000,
      ST_SETUP = 5'b10000
   } prupk_st_e;

   prupk_st_e state;
   logic [3:0] align;
   logic [31:0] base;
   logic [15:0] width;
   logic [15:0] height;
   logic err_range;
   logic err_combo;
   // Settings captured at command time
   prupk_pkg::prupk_fmt_e cmd_fmt;
   prupk_pkg::prupk_typ_e cmd_typ;
   logic [3:0] cmd_align;
   logic [31:0] row_addr;
   logic [31:0] elem_addr;
   logic [31:0] stride;
   logic [15:0] col;
   logic [15:0] row;
   logic [1:0] eidx;
   logic [1:0] elems;
   logic [7:0] ebuf [0:3];
   logic [15:0] pword;
   logic acc_done;

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   wire bus_acc = (i_avs_read | i_avs_write) & ~acc_done;
   // Writes land on the answer edge, where the master sees waitrequest low
   wire bus_wr = i_avs_write & acc_done;
   wire wr_ctrl = bus_wr & (i_avs_address == prupk_pkg::REG_CTRL) & i_avs_byteenable[0];
   wire [2:0] w_fmt = i_avs_writedata[prupk_pkg::CTRL_FMT_LSB +: 3];
   wire [1:0] w_typ = i_avs_writedata[prupk_pkg::CTRL_TYPE_LSB +: 2];
   wire start_req = wr_ctrl & i_avs_writedata[prupk_pkg::CTRL_START_BIT];
   logic combo_ok;

   always_comb begin
      // Only the eight legal pairs; packed types must match component count
      case (w_typ)
         prupk_pkg::TYP_UBYTE: combo_ok = (w_fmt <= 3'(prupk_pkg::FMT_GREY_ALPHA));
         prupk_pkg::TYP_P565: combo_ok = (w_fmt == 3'(prupk_pkg::FMT_RGB));
         default: combo_ok = (w_fmt == 3'(prupk_pkg::FMT_RGBA));
      endcase
   end

   wire launch = start_req & combo_ok & (state == ST_IDLE);
   wire align_ok = (i_avs_writedata[3:0] == 4'h1) | (i_avs_writedata[3:0] == 4'h2) |
      (i_avs_writedata[3:0] == 4'h4) | (i_avs_writedata[3:0] == 4'h8);
   wire align_wr = bus_wr & (i_avs_address == prupk_pkg::REG_ALIGN) & i_avs_byteenable[0];

   // ----------------------------------------------------------------
   // Avalon slave: one wait cycle, answer on the second
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         acc_done <= 1'b0;
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h0000_0000;
      end else begin
         acc_done <= bus_acc;
         o_avs_waitrequest <= ~bus_acc;
         if (bus_acc & i_avs_read) begin
            case (i_avs_address)
               prupk_pkg::REG_CTRL: o_avs_readdata <= {28'h0000000, err_combo, err_range, 1'b0, state != ST_IDLE};
               prupk_pkg::REG_ALIGN: o_avs_readdata <= {28'h0000000, align};
               prupk_pkg::REG_BASE: o_avs_readdata <= base;
               prupk_pkg::REG_SIZE: o_avs_readdata <= {height, width};
               default: o_avs_readdata <= prupk_pkg::READ_UNMAPPED;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Settings registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         align <= prupk_pkg::ALIGN_RESET;
         base <= 32'h0000_0000;
         width <= 16'h0000;
         height <= 16'h0000;
      end else begin
         if (align_wr & align_ok) begin
            align <= i_avs_writedata[3:0];
         end
         if (bus_wr & (i_avs_address == prupk_pkg::REG_BASE)) begin
            base <= i_avs_writedata;
         end
         if (bus_wr & (i_avs_address == prupk_pkg::REG_SIZE)) begin
            width <= i_avs_writedata[15:0];
            height <= i_avs_writedata[31:16];
         end
      end
   end

   // Error flags: a new error wins over a clear in the same write
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         err_range <= 1'b0;
         err_combo <= 1'b0;
      end else begin
         if (align_wr & ~align_ok) begin
            err_range <= 1'b1;
         end else if (wr_ctrl & i_avs_writedata[prupk_pkg::CTRL_CLRERR_BIT]) begin
            err_range <= 1'b0;
         end
         if (start_req & ~combo_ok) begin
            err_combo <= 1'b1;
         end else if (wr_ctrl & i_avs_writedata[prupk_pkg::CTRL_CLRERR_BIT]) begin
            err_combo <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Row stride: s*n*l bytes, padded to alignment for bytes and packed words alike
   // ----------------------------------------------------------------
   logic [31:0] row_bytes;
   logic [31:0] stride_calc;

   always_comb begin
      // Packed words count as a one-element group of two bytes
      if (cmd_typ != prupk_pkg::TYP_UBYTE) begin
         row_bytes = {15'h0000, width, 1'b0};
      end else begin
         row_bytes = 32'(width) * 32'({2'b00, elems} + 4'h1);
      end
      // s*n*l rounded up to a multiple of a equals (a/s)*ceil(s*n*l/a) in elements
      stride_calc = (row_bytes + 32'(cmd_align) - 32'h1) & ~(32'(cmd_align) - 32'h1);
      // Element sizes are 8 or 16 bits only, so the odd-width fallback never applies
      if ((cmd_typ != prupk_pkg::TYP_UBYTE) && (cmd_align <= 4'h2)) begin
         stride_calc = row_bytes;
      end
   end

   // ----------------------------------------------------------------
   // Walker
   // ----------------------------------------------------------------
   wire last_elem = (eidx == elems);
   wire last_col = (col == width - 16'h1);
   wire last_row = (row == height - 16'h1);

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= ST_IDLE;
         cmd_fmt <= prupk_pkg::FMT_RGBA;
         cmd_typ <= prupk_pkg::TYP_UBYTE;
         cmd_align <= prupk_pkg::ALIGN_RESET;
         elems <= 2'h0;
         stride <= 32'h0000_0000;
         row_addr <= 32'h0000_0000;
         elem_addr <= 32'h0000_0000;
         col <= 16'h0000;
         row <= 16'h0000;
         eidx <= 2'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (launch) begin
                  cmd_fmt <= prupk_pkg::prupk_fmt_e'(w_fmt);
                  cmd_typ <= prupk_pkg::prupk_typ_e'(w_typ);
                  cmd_align <= align;
                  case (w_fmt)
                     3'(prupk_pkg::FMT_RGB): elems <= (w_typ == 2'(prupk_pkg::TYP_UBYTE)) ? 2'h2 : 2'h0;
                     3'(prupk_pkg::FMT_RGBA): elems <= (w_typ == 2'(prupk_pkg::TYP_UBYTE)) ? 2'h3 : 2'h0;
                     3'(prupk_pkg::FMT_GREY_ALPHA): elems <= 2'h1;
                     default: elems <= 2'h0;
                  endcase
                  row_addr <= base;
                  elem_addr <= base;
                  col <= 16'h0000;
                  row <= 16'h0000;
                  eidx <= 2'h0;
                  state <= ((width == 16'h0000) || (height == 16'h0000)) ? ST_IDLE : ST_SETUP;
               end
            end
            ST_SETUP: begin
               stride <= stride_calc;
               state <= ST_REQ;
            end
            ST_REQ: begin
               if (i_mem_req_ready) begin
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (i_mem_rvalid) begin
                  elem_addr <= elem_addr + ((cmd_typ == prupk_pkg::TYP_UBYTE) ? 32'h1 : 32'h2);
                  if (last_elem) begin
                     state <= ST_EMIT;
                  end else begin
                     eidx <= eidx + 2'h1;
                     state <= ST_REQ;
                  end
               end
            end
            ST_EMIT: begin
               if (o_pix_valid & i_pix_ready) begin
                  eidx <= 2'h0;
                  if (last_col) begin
                     col <= 16'h0000;
                     row <= row + 16'h1;
                     row_addr <= row_addr + stride;
                     elem_addr <= row_addr + stride;
                     state <= last_row ? ST_IDLE : ST_REQ;
                  end else begin
                     col <= col + 16'h1;
                     state <= ST_REQ;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Memory request outputs
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_mem_req <= '0;
         o_mem_req_valid <= 1'b0;
      end else begin
         o_mem_req_valid <= (state == ST_SETUP) | (state == ST_WAIT & i_mem_rvalid & ~last_elem) |
            (state == ST_EMIT & o_pix_valid & i_pix_ready & ~(last_col & last_row)) |
            (state == ST_REQ & ~i_mem_req_ready);
         if (state == ST_WAIT & i_mem_rvalid) begin
            o_mem_req.addr <= elem_addr + ((cmd_typ == prupk_pkg::TYP_UBYTE) ? 32'h1 : 32'h2);
         end else if (state == ST_EMIT & last_col) begin
            o_mem_req.addr <= row_addr + stride;
         end else if (state == ST_SETUP) begin
            o_mem_req.addr <= elem_addr;
         end
         o_mem_req.size_log2 <= (cmd_typ == prupk_pkg::TYP_UBYTE) ? prupk_pkg::MSIZE_BYTE : prupk_pkg::MSIZE_HALF;
      end
   end

   // Element capture, one slot per element position
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_ebuf
         always_ff @(posedge i_sys_clk or posedge i_rst) begin
            if (i_rst) begin
               ebuf[gi] <= 8'h00;
            end else if (state == ST_WAIT & i_mem_rvalid & eidx == 2'(gi)) begin
               ebuf[gi] <= i_mem_rdata[7:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         pword <= 16'h0000;
      end else if (state == ST_WAIT & i_mem_rvalid) begin
         pword <= i_mem_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Normalization to 8-bit unit values and RGBA expansion
   // ----------------------------------------------------------------
   // Bit replication: exact at both ends, within one step of c/(2^b-1) between
   function automatic logic [7:0] norm5(input logic [4:0] v);
      norm5 = {v, v[4:2]};
   endfunction : norm5

   function automatic logic [7:0] norm6(input logic [5:0] v);
      norm6 = {v, v[5:4]};
   endfunction : norm6

   function automatic logic [7:0] norm4(input logic [3:0] v);
      norm4 = {v, v};
   endfunction : norm4

   prupk_pkg::prupk_rgba_s next_pix;

   always_comb begin
      next_pix = '{r: prupk_pkg::NORM_ZERO, g: prupk_pkg::NORM_ZERO, b: prupk_pkg::NORM_ZERO,
         a: prupk_pkg::NORM_ONE};
      case (cmd_typ)
         // Fields are unsigned, MSB first; pword is right-justified already
         prupk_pkg::TYP_P565: begin
            next_pix.r = norm5(pword[15:11]);
            next_pix.g = norm6(pword[10:5]);
            next_pix.b = norm5(pword[4:0]);
         end
         prupk_pkg::TYP_P4444: begin
            next_pix.r = norm4(pword[15:12]);
            next_pix.g = norm4(pword[11:8]);
            next_pix.b = norm4(pword[7:4]);
            next_pix.a = norm4(pword[3:0]);
         end
         prupk_pkg::TYP_P5551: begin
            next_pix.r = norm5(pword[15:11]);
            next_pix.g = norm5(pword[10:6]);
            next_pix.b = norm5(pword[5:1]);
            next_pix.a = {8{pword[0]}};
         end
         default: begin
            // Bytes are already unit values over 255
            case (cmd_fmt)
               prupk_pkg::FMT_ALPHA: next_pix.a = ebuf[0];
               prupk_pkg::FMT_RGB: begin
                  next_pix.r = ebuf[0];
                  next_pix.g = ebuf[1];
                  next_pix.b = ebuf[2];
               end
               prupk_pkg::FMT_GREY: begin
                  next_pix.r = ebuf[0];
                  next_pix.g = ebuf[0];
                  next_pix.b = ebuf[0];
               end
               prupk_pkg::FMT_GREY_ALPHA: begin
                  next_pix.r = ebuf[0];
                  next_pix.g = ebuf[0];
                  next_pix.b = ebuf[0];
                  next_pix.a = ebuf[1];
               end
               default: begin
                  next_pix.r = ebuf[0];
                  next_pix.g = ebuf[1];
                  next_pix.b = ebuf[2];
                  next_pix.a = ebuf[3];
               end
            endcase
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Output stream
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pix <= '0;
         o_pix_valid <= 1'b0;
         o_pix_last <= 1'b0;
      end else begin
         // Valid rises together with settled group data, never ahead of it
         if (state == ST_EMIT & ~o_pix_valid) begin
            o_pix_valid <= 1'b1;
            o_pix_last <= last_col & last_row;
            o_pix <= next_pix;
         end else if (o_pix_valid & i_pix_ready) begin
            o_pix_valid <= 1'b0;
            o_pix_last <= 1'b0;
         end
      end
   end

endmodule : prupk_top

// *** include/prupk_pkg.sv ***
// Package of constants and types for the pixel rectangle unpacker
package prupk_pkg;

   // ----------------------------------------------------------------
   // Register map (word aligned byte addresses)
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ALIGN = 4'h4;
   localparam logic [3:0] REG_BASE = 4'h8;
   localparam logic [3:0] REG_SIZE = 4'hC;

   // CTRL write fields
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_CLRERR_BIT = 1;
   localparam int CTRL_FMT_LSB = 4;
   localparam int CTRL_TYPE_LSB = 8;
   // CTRL read fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_RANGE_BIT = 2;
   localparam int STAT_COMBO_BIT = 3;

   localparam logic [3:0] ALIGN_RESET = 4'h4;
   localparam logic [31:0] READ_UNMAPPED = 32'hDEADBEEF;

   // ----------------------------------------------------------------
   // Formats and element types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      FMT_ALPHA = 3'h0,
      FMT_RGB = 3'h1,
      FMT_RGBA = 3'h2,
      FMT_GREY = 3'h3,
      FMT_GREY_ALPHA = 3'h4
   } prupk_fmt_e;

   typedef enum logic [1:0] {
      TYP_UBYTE = 2'h0,
      TYP_P565 = 2'h1,
      TYP_P4444 = 2'h2,
      TYP_P5551 = 2'h3
   } prupk_typ_e;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
      logic [7:0] a;
   } prupk_rgba_s;

   typedef struct packed {
      logic [31:0] addr;
      logic [1:0] size_log2;
   } prupk_mreq_s;

   localparam logic [1:0] MSIZE_BYTE = 2'h0;
   localparam logic [1:0] MSIZE_HALF = 2'h1;
   localparam logic [7:0] NORM_ONE = 8'hFF;
   localparam logic [7:0] NORM_ZERO = 8'h00;

endpackage : prupk_pkg

// *** verif/prupk_chk.sv ***
// Port checker for the pixel rectangle unpacker, bound to its top
`timescale 1ns/10ps
module prupk_chk (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire prupk_pkg::prupk_mreq_s o_mem_req,
   input wire logic o_mem_req_valid,
   input wire logic i_mem_req_ready,
   input wire prupk_pkg::prupk_rgba_s o_pix,
   input wire logic o_pix_valid,
   input wire logic i_pix_ready
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   prupk_pkg::prupk_fmt_e fmt_q;
   logic [1:0] typ_q;
   // Format of the command in flight, caught from the start write
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         fmt_q <= prupk_pkg::FMT_RGBA;
         typ_q <= 2'h0;
      end else if (i_avs_write && i_avs_address == prupk_pkg::REG_CTRL && i_avs_writedata[0]) begin
         fmt_q <= prupk_pkg::prupk_fmt_e'(i_avs_writedata[6:4]);
         typ_q <= i_avs_writedata[9:8];
      end
   end
   // Group data stands from the first valid cycle
   sequence s_pix_seen;
      o_pix_valid;
   endsequence
   sequence s_pix_held;
      o_pix_valid && !i_pix_ready;
   endsequence
   property p_wait_one;
      (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
   endproperty
   property p_align_range;
      i_avs_read && i_avs_address == prupk_pkg::REG_ALIGN && !o_avs_waitrequest
         |-> o_avs_readdata inside {32'h1, 32'h2, 32'h4, 32'h8};
   endproperty
   property p_req_hold;
      o_mem_req_valid && !i_mem_req_ready |=> o_mem_req_valid && $stable(o_mem_req);
   endproperty
   property p_req_single;
      o_mem_req_valid && i_mem_req_ready |=> !o_mem_req_valid;
   endproperty
   property p_req_size;
      o_mem_req_valid |-> o_mem_req.size_log2 == ((typ_q == 2'h0) ? prupk_pkg::MSIZE_BYTE : prupk_pkg::MSIZE_HALF);
   endproperty
   property p_pix_hold;
      s_pix_held |=> o_pix_valid && $stable(o_pix);
   endproperty
   property p_alpha_one;
      s_pix_seen |-> (fmt_q != prupk_pkg::FMT_RGB && fmt_q != prupk_pkg::FMT_GREY) || o_pix.a == prupk_pkg::NORM_ONE;
   endproperty
   property p_grey_copy;
      s_pix_seen |-> (fmt_q != prupk_pkg::FMT_GREY && fmt_q != prupk_pkg::FMT_GREY_ALPHA)
         || (o_pix.r == o_pix.g && o_pix.g == o_pix.b);
   endproperty
   property p_alpha_only;
      s_pix_seen |-> fmt_q != prupk_pkg::FMT_ALPHA || {o_pix.r, o_pix.g, o_pix.b} == 24'h000000;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("register access not answered after one wait");
   a_align_range: assert property (p_align_range) else $error("alignment outside its legal set");
   a_req_hold: assert property (p_req_hold) else $error("fetch request changed while stalled");
   a_req_single: assert property (p_req_single) else $error("second fetch issued before data");
   a_req_size: assert property (p_req_size) else $error("fetch size does not suit the type");
   a_pix_hold: assert property (p_pix_hold) else $error("group changed while stalled");
   a_alpha_one: assert property (p_alpha_one) else $error("absent alpha not one");
   a_grey_copy: assert property (p_grey_copy) else $error("grey not copied to colour");
   a_alpha_only: assert property (p_alpha_only) else $error("absent colour not zero");
endmodule : prupk_chk

bind prupk_top prupk_chk i_prupk_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_mem_req(o_mem_req),
   .o_mem_req_valid(o_mem_req_valid), .i_mem_req_ready(i_mem_req_ready), .o_pix(o_pix),
   .o_pix_valid(o_pix_valid), .i_pix_ready(i_pix_ready));

// *** verif/prupk_mem_model.sv ***
// Client memory model answering element fetches with alternating latency
`timescale 1ns/10ps
module prupk_mem_model (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire prupk_pkg::prupk_mreq_s i_req,
   input wire logic i_req_valid,
   output logic o_req_ready,
   output logic [15:0] o_rdata,
   output logic o_rvalid
);
   prupk_pkg::prupk_mreq_s held;
   logic pend;
   logic slow;
   logic [1:0] dly;
   // Content depends on address, so a wrong row start shows up in the data
   function automatic logic [7:0] mv(input logic [31:0] a);
      return 8'(a[7:0] * 8'h25 + 8'h0B);
   endfunction : mv
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_req_ready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= 16'h0000;
         pend <= 1'b0;
         slow <= 1'b0;
         dly <= 2'h0;
      end else begin
         o_req_ready <= !o_req_ready && !pend;
         o_rvalid <= 1'b0;
         // Idle data keeps moving so a sample taken outside the pulse is caught
         o_rdata <= ~o_rdata;
         if (i_req_valid && o_req_ready) begin
            held <= i_req;
            pend <= 1'b1;
            dly <= slow ? 2'h2 : 2'h0;
            slow <= !slow;
         end else if (pend && dly != 2'h0) begin
            dly <= dly - 2'h1;
         end else if (pend) begin
            pend <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= {(held.size_log2 == prupk_pkg::MSIZE_BYTE) ? ~mv(held.addr) : mv(held.addr + 1),
               mv(held.addr)};
         end
      end
   end
endmodule : prupk_mem_model

// *** verif/prupk_tb_top.sv ***
// Self-checking testbench for the pixel rectangle unpacker
`timescale 1ns/10ps
module prupk_tb_top;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   prupk_pkg::prupk_mreq_s mem_req;
   logic mem_req_valid;
   logic mem_req_ready;
   logic [15:0] mem_rdata;
   logic mem_rvalid;
   prupk_pkg::prupk_rgba_s pix;
   logic pix_valid;
   logic pix_ready = 1'b0;
   logic pix_last;
   logic [1:0] pace = 2'h0;
   int err_total = 0;
   int checked = 0;
   prupk_pkg::prupk_rgba_s got[$];
   logic last_q[$];
   prupk_top i_prupk_top (.i_sys_clk(sys_clk), .i_rst(rst), .i_avs_address(avs_address), .i_avs_read(avs_read),
      .i_avs_write(avs_write), .i_avs_writedata(avs_writedata), .i_avs_byteenable(4'hF),
      .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest), .o_mem_req(mem_req),
      .o_mem_req_valid(mem_req_valid), .i_mem_req_ready(mem_req_ready), .i_mem_rdata(mem_rdata),
      .i_mem_rvalid(mem_rvalid), .o_pix(pix), .o_pix_valid(pix_valid), .i_pix_ready(pix_ready),
      .o_pix_last(pix_last));
   prupk_mem_model i_prupk_mem_model (.i_sys_clk(sys_clk), .i_rst(rst), .i_req(mem_req),
      .i_req_valid(mem_req_valid), .o_req_ready(mem_req_ready), .o_rdata(mem_rdata), .o_rvalid(mem_rvalid));
   initial begin
      forever #25 sys_clk = ~sys_clk;
   end
   // Consumer never accepts in the first valid cycle and stalls two cycles in four
   always @(posedge sys_clk) begin
      pace <= pace + 2'h1;
      if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
         got.push_back(pix);
         last_q.push_back(pix_last);
         pix_ready <= 1'b0;
      end else begin
         pix_ready <= pix_valid && pace[1];
      end
   end
   task automatic acc(input logic is_wr, input logic [3:0] ad, input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      avs_address <= ad;
      avs_read <= !is_wr;
      avs_write <= is_wr;
      avs_writedata <= d;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : acc
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict
   function automatic prupk_pkg::prupk_rgba_s exp_pix(input int f, input int t, input logic [31:0] a);
      logic [7:0] b0;
      logic [7:0] b1;
      logic [15:0] w;
      b0 = i_prupk_mem_model.mv(a);
      b1 = i_prupk_mem_model.mv(a + 1);
      w = {b1, b0};
      case (t)
         1: return {w[15:11], w[15:13], w[10:5], w[10:9], w[4:0], w[4:2], 8'hFF};
         2: return {w[15:12], w[15:12], w[11:8], w[11:8], w[7:4], w[7:4], w[3:0], w[3:0]};
         3: return {w[15:11], w[15:13], w[10:6], w[10:8], w[5:1], w[5:3], {8{w[0]}}};
         default: case (f)
            0: return {24'h000000, b0};
            1: return {b0, b1, i_prupk_mem_model.mv(a + 2), 8'hFF};
            2: return {b0, b1, i_prupk_mem_model.mv(a + 2), i_prupk_mem_model.mv(a + 3)};
            3: return {b0, b0, b0, 8'hFF};
            default: return {b0, b0, b0, b1};
         endcase
      endcase
   endfunction : exp_pix
   task automatic run(input int f, input int t, input int w, input int h, input int al, input int base, input bit late);
      int bpp;
      int stride;
      logic [31:0] q;
      bpp = (t != 0) ? 2 : (f == 2) ? 4 : (f == 1) ? 3 : (f == 4) ? 2 : 1;
      stride = (bpp * w + al - 1) / al * al;
      got.delete();
      last_q.delete();
      acc(1'b1, prupk_pkg::REG_ALIGN, al, q);
      acc(1'b1, prupk_pkg::REG_BASE, base, q);
      acc(1'b1, prupk_pkg::REG_SIZE, h * 65536 + w, q);
      acc(1'b1, prupk_pkg::REG_CTRL, t * 256 + f * 16 + 1, q);
      if (late) acc(1'b1, prupk_pkg::REG_ALIGN, 32'h1, q);
      q = 32'h1;
      for (int n = 0; n < 500 && q[0] !== 1'b0; n++) acc(1'b0, prupk_pkg::REG_CTRL, 32'h0, q);
      chk("idle", q[0], 1'b0);
      chk("groups", got.size(), w * h);
      foreach (got[n]) begin
         chk("group", got[n], exp_pix(f, t, base + n / w * stride + n % w * bpp));
         chk("last", last_q[n], n == w * h - 1);
      end
      $display("test format %0d type %0d align %0d done", f, t, al);
   endtask : run
   initial begin
      logic [31:0] q;
      logic [31:0] bad[3];
      logic [7:0] pairs[8];
      bad = '{32'h121, 32'h211, 32'h301};
      pairs = '{8'h20, 8'h10, 8'h22, 8'h23, 8'h11, 8'h40, 8'h30, 8'h00};
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      acc(1'b0, prupk_pkg::REG_ALIGN, 32'h0, q);
      chk("align reset", q, 32'h4);
      acc(1'b1, prupk_pkg::REG_ALIGN, 32'h3, q);
      acc(1'b0, prupk_pkg::REG_ALIGN, 32'h0, q);
      chk("align kept", q, 32'h4);
      acc(1'b0, prupk_pkg::REG_CTRL, 32'h0, q);
      chk("range flag", q[2], 1'b1);
      acc(1'b0, 4'h1, 32'h0, q);
      chk("unmapped", q, prupk_pkg::READ_UNMAPPED);
      $display("test registers done");
      foreach (bad[i]) begin
         acc(1'b1, prupk_pkg::REG_CTRL, 32'h2, q);
         acc(1'b1, prupk_pkg::REG_CTRL, bad[i], q);
         acc(1'b0, prupk_pkg::REG_CTRL, 32'h0, q);
         chk("pair refused", {q[3:2], q[0]}, 3'b100);
      end
      chk("no groups", got.size(), 0);
      $display("test refused pairs done");
      foreach (pairs[i]) run(pairs[i][7:4], pairs[i][1:0], 3, 2, 4, 32'h40 * i, 1'b0);
      for (int al = 1; al <= 8; al = al * 2) run(1, 0, 3, 3, al, 32'h200, al == 8);
      run(1, 1, 3, 2, 8, 32'h280, 1'b0);
      give_verdict();
   end
   initial begin
      repeat (50000) @(posedge sys_clk);
      err_total++;
      give_verdict();
   end
endmodule : prupk_tb_top
